// ---- logic/iep_bank.sv ----
// Interrupt enable and priority bank with timed block, APB register slave
`include "iep_consts.svh"
`default_nettype none
module iep_bank #(
  parameter int unsigned BLOCK_W = 14,
  parameter logic [2:0] OTHER_LEVEL = `IEP_OTHER_LEVEL
) (
  input wire logic SYS_CLK, // System clock, 50 MHz
  input wire logic RST_N, // Synchronous reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB direction, high for write
  input wire logic [11:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  input wire logic [3:0] PSTRB, // APB byte strobes
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error, unmapped address
  input wire logic [14:0] SRC_FLAG, // Request flags of the sources
  input wire logic BLOCK_START, // Timed block instruction, pulse
  input wire logic [BLOCK_W-1:0] BLOCK_COUNT, // Block operand
  input wire logic INSN_DONE, // Instruction retired, pulse
  output logic [14:0] SRC_PASS, // Requests passed onward
  output logic IRQ_REQ, // Request presented to the CPU
  output logic [3:0] IRQ_SRC, // Source being presented
  output logic [2:0] IRQ_LEVEL, // Level being presented
  output logic BLOCK_ACTIVE, // Timed block window open
  output logic IRQ_NOTIFY // Unmasked bank event pending
);
  localparam int unsigned NSRC = 15;

  // Register state
  logic [15:0] source_enable_0_q;
  logic [15:0] source_priority_2_q;
  logic [1:0] evt_stat_q;
  logic [1:0] evt_mask_q;
  logic [14:0] pass_q;
  logic irq_req_q;
  iep_pkg::iep_src_t irq_src_q;
  iep_pkg::iep_level_t irq_level_q;
  logic block_was_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  iep_pkg::iep_apb_state_t apb_q;
  iep_pkg::iep_apb_state_t apb_d;

  // Combinational helpers
  logic [3*NSRC-1:0] levels;
  logic [14:0] eligible;
  logic [14:0] pass_d;
  logic pick_valid;
  iep_pkg::iep_src_t pick_idx;
  iep_pkg::iep_level_t pick_level;
  logic block_on;
  logic [BLOCK_W-1:0] block_left;
  logic held_off;
  logic window_end;
  logic wr_take;
  logic rd_take;
  logic [15:0] wmask;
  logic [31:0] rd_word;
  logic rd_hit;

  // Address decode shared by the read mux and the write paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // Level of a source: four sources have fields, the rest a fixed level
  function automatic iep_pkg::iep_level_t level_of(input int unsigned s,
                                                   input logic [15:0] p);
    if (s == `IEP_SRC_SERIAL_RX) begin
      level_of = p[`IEP_POS_SERIAL_RX_LEVEL +: 3];
    end else if (s == `IEP_SRC_SPI_EVENT) begin
      level_of = p[`IEP_POS_SPI_EVENT_LEVEL +: 3];
    end else if (s == `IEP_SRC_SPI_ERROR) begin
      level_of = p[`IEP_POS_SPI_ERROR_LEVEL +: 3];
    end else if (s == `IEP_SRC_TIMER_THREE) begin
      level_of = p[`IEP_POS_TIMER_THREE_LEVEL +: 3];
    end else begin
      level_of = OTHER_LEVEL;
    end
  endfunction

  // Per-source gating; level seven is the only one that beats the block
  generate
    for (genvar g = 0; g < NSRC; g++) begin : g_src
      assign levels[3*g +: 3] = level_of(g, source_priority_2_q);
      assign eligible[g] = SRC_FLAG[g] && source_enable_0_q[g]
        && (levels[3*g +: 3] != `IEP_LEVEL_OFF);
      assign pass_d[g] = eligible[g]
        && (!block_on || (levels[3*g +: 3] == `IEP_LEVEL_TOP));
    end
  endgenerate

  // Instruction-counted block window
  iep_block_timer #(
    .BLOCK_W(BLOCK_W)
  ) u_block (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .start(BLOCK_START),
    .count(BLOCK_COUNT),
    .insn_done(INSN_DONE),
    .remaining(block_left),
    .active(block_on)
  );

  // Highest level among passed requests
  iep_prio_pick #(
    .NSRC(NSRC)
  ) u_pick (
    .req(pass_d),
    .lvl(levels),
    .valid(pick_valid),
    .idx(pick_idx),
    .level(pick_level)
  );

  // Bank events for the notify output
  assign held_off = |(eligible & ~pass_d);
  assign window_end = block_was_q && !block_on;

  // APB: one wait cycle so read data comes from a flop
  assign wr_take = PSEL && PENABLE && PWRITE && (apb_q == iep_pkg::AP_ANSWER);
  assign rd_take = PSEL && PENABLE && (apb_q == iep_pkg::AP_IDLE);
  assign wmask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};

  // Access phase state
  always_comb begin
    apb_d = apb_q;
    case (apb_q)
      iep_pkg::AP_IDLE: begin
        if (PSEL && PENABLE) begin
          apb_d = iep_pkg::AP_ANSWER;
        end
      end
      iep_pkg::AP_ANSWER: begin
        apb_d = iep_pkg::AP_IDLE;
      end
      default: begin
        apb_d = iep_pkg::AP_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      apb_q <= iep_pkg::AP_IDLE;
    end else begin
      apb_q <= apb_d;
    end
  end

  // Read mux; unimplemented bits come back as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (hit(PADDR, `IEP_OFS_ENABLE)) begin
      rd_word[15:0] = source_enable_0_q & `IEP_ENABLE_MASK;
    end else if (hit(PADDR, `IEP_OFS_PRIORITY)) begin
      rd_word[15:0] = source_priority_2_q & `IEP_PRIORITY_MASK;
    end else if (hit(PADDR, `IEP_OFS_BLOCK)) begin
      rd_word[BLOCK_W-1:0] = block_left;
      rd_word[31] = block_on;
    end else if (hit(PADDR, `IEP_OFS_PASS)) begin
      rd_word[14:0] = pass_q;
    end else if (hit(PADDR, `IEP_OFS_EVT_STAT)) begin
      rd_word[1:0] = evt_stat_q;
    end else if (hit(PADDR, `IEP_OFS_EVT_MASK)) begin
      rd_word[1:0] = evt_mask_q;
    end else if (hit(PADDR, `IEP_OFS_PRESENT)) begin
      rd_word[7] = irq_req_q;
      rd_word[6:4] = irq_level_q;
      rd_word[3:0] = irq_src_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read data and error captured in the first access cycle
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (rd_take) begin
      prdata_q <= PWRITE ? 32'h0000_0000 : rd_word;
      pslverr_q <= !rd_hit;
    end
  end

  // Enable register; bit 15 is not stored
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      source_enable_0_q <= `IEP_ENABLE_RESET;
    end else if (wr_take && hit(PADDR, `IEP_OFS_ENABLE)) begin
      source_enable_0_q <= ((PWDATA[15:0] & wmask)
        | (source_enable_0_q & ~wmask)) & `IEP_ENABLE_MASK;
    end
  end

  // Priority register; spare bits between fields are not stored
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      source_priority_2_q <= `IEP_PRIORITY_RESET;
    end else if (wr_take && hit(PADDR, `IEP_OFS_PRIORITY)) begin
      source_priority_2_q <= ((PWDATA[15:0] & wmask)
        | (source_priority_2_q & ~wmask)) & `IEP_PRIORITY_MASK;
    end
  end

  // Event mask
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      evt_mask_q <= 2'h0;
    end else if (wr_take && PSTRB[0] && hit(PADDR, `IEP_OFS_EVT_MASK)) begin
      evt_mask_q <= PWDATA[1:0] & `IEP_EVT_MASK_BITS;
    end
  end

  // Sticky events, write one to clear; a new event outranks the clear
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      evt_stat_q <= 2'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if ((b == `IEP_EVT_WINDOW_END) ? window_end : held_off) begin
          evt_stat_q[b] <= 1'b1;
        end else if (wr_take && PSTRB[0] && PWDATA[b]
                     && hit(PADDR, `IEP_OFS_EVT_STAT)) begin
          evt_stat_q[b] <= 1'b0;
        end
      end
    end
  end

  // Window edge tracking for the end event
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      block_was_q <= 1'b0;
    end else begin
      block_was_q <= block_on;
    end
  end

  // Presented request, one cycle behind the flags
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pass_q <= 15'h0000;
      irq_req_q <= 1'b0;
      irq_src_q <= 4'h0;
      irq_level_q <= 3'h0;
    end else begin
      pass_q <= pass_d;
      irq_req_q <= pick_valid;
      irq_src_q <= pick_valid ? pick_idx : 4'h0;
      irq_level_q <= pick_level;
    end
  end

  // Outputs
  assign PRDATA = prdata_q;
  assign PREADY = (apb_q == iep_pkg::AP_ANSWER);
  assign PSLVERR = (apb_q == iep_pkg::AP_ANSWER) && pslverr_q;
  assign SRC_PASS = pass_q;
  assign IRQ_REQ = irq_req_q;
  assign IRQ_SRC = irq_src_q;
  assign IRQ_LEVEL = irq_level_q;
  assign BLOCK_ACTIVE = block_on;
  assign IRQ_NOTIFY = |(evt_stat_q & evt_mask_q);
endmodule
`default_nettype wire

// ---- logic/iep_consts.svh ----
// Register offsets, field positions and reset values of the enable/priority bank
`ifndef IEP_CONSTS_SVH
`define IEP_CONSTS_SVH

// Register byte offsets
`define IEP_OFS_ENABLE 12'h000
`define IEP_OFS_PRIORITY 12'h004
`define IEP_OFS_BLOCK 12'h008
`define IEP_OFS_PASS 12'h00C
`define IEP_OFS_EVT_STAT 12'h010
`define IEP_OFS_EVT_MASK 12'h014
`define IEP_OFS_PRESENT 12'h018

// Implemented bits and reset values
`define IEP_ENABLE_MASK 16'h7FFF
`define IEP_ENABLE_RESET 16'h0000
`define IEP_PRIORITY_MASK 16'h7777
`define IEP_PRIORITY_RESET 16'h4444
`define IEP_EVT_MASK_BITS 2'h3

// Priority field positions (low bit of each 3-bit field)
`define IEP_POS_SERIAL_RX_LEVEL 12
`define IEP_POS_SPI_EVENT_LEVEL 8
`define IEP_POS_SPI_ERROR_LEVEL 4
`define IEP_POS_TIMER_THREE_LEVEL 0

// Source positions in the enable register
`define IEP_SRC_SERIAL_RX 11
`define IEP_SRC_SPI_EVENT 10
`define IEP_SRC_SPI_ERROR 9
`define IEP_SRC_TIMER_THREE 8

// Levels
`define IEP_LEVEL_TOP 3'h7
`define IEP_LEVEL_OFF 3'h0
`define IEP_OTHER_LEVEL 3'h4

// Event status bits
`define IEP_EVT_WINDOW_END 0
`define IEP_EVT_HELD_OFF 1

`endif

// ---- logic/iep_pkg.sv ----
// Types shared by the enable/priority bank
`default_nettype none
package iep_pkg;
  typedef logic [2:0] iep_level_t;
  typedef logic [3:0] iep_src_t;
  typedef enum logic [1:0] {
    AP_IDLE,
    AP_ANSWER
  } iep_apb_state_t;
endpackage
`default_nettype wire

// ---- logic/iep_prio_pick.sv ----
// Picks the highest-level pending request among the sources
`default_nettype none
module iep_prio_pick #(
  parameter int unsigned NSRC = 15
) (
  input wire logic [NSRC-1:0] req, // Gated requests
  input wire logic [3*NSRC-1:0] lvl, // Level of each source, packed
  output logic valid, // Some request pending
  output iep_pkg::iep_src_t idx, // Winning source
  output iep_pkg::iep_level_t level // Winning level
);
  // Strictly greater wins, so ties go to the lowest source number
  always_comb begin
    level = 3'h0;
    idx = 4'h0;
    for (int i = 0; i < NSRC; i++) begin
      if (req[i] && (lvl[3*i +: 3] > level)) begin
        level = lvl[3*i +: 3];
        idx = 4'(i);
      end
    end
    valid = (level != 3'h0);
  end
endmodule
`default_nettype wire

// ---- logic/iep_block_timer.sv ----
// Counts down the instructions of a timed interrupt-block window
`default_nettype none
module iep_block_timer #(
  parameter int unsigned BLOCK_W = 14
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic start, // Block instruction executed, one pulse
  input wire logic [BLOCK_W-1:0] count, // Instructions to block
  input wire logic insn_done, // One instruction retired, pulse
  output logic [BLOCK_W-1:0] remaining, // Instructions still blocked
  output logic active // Window open
);
  logic [BLOCK_W-1:0] remaining_q;

  // Start reloads even mid-window, a new block replaces the old one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remaining_q <= '0;
    end else if (start) begin
      remaining_q <= count;
    end else if (insn_done && (remaining_q != '0)) begin
      remaining_q <= remaining_q - BLOCK_W'(1);
    end
  end

  assign remaining = remaining_q;
  assign active = (remaining_q != '0);
endmodule
`default_nettype wire

// ---- sim/iep_bank_sva.sv ----
// Port checker of the enable/priority bank, bound to the top module
`default_nettype none
module iep_bank_sva #(
  parameter int unsigned BLOCK_W = 14
) (
  input wire logic SYS_CLK, // Clock
  input wire logic RST_N, // Reset, active low
  input wire logic PREADY, // APB ready
  input wire logic PSLVERR, // APB error
  input wire logic [14:0] SRC_FLAG, // Source flags
  input wire logic BLOCK_START, // Block pulse
  input wire logic [BLOCK_W-1:0] BLOCK_COUNT, // Block operand
  input wire logic INSN_DONE, // Retire pulse
  input wire logic [14:0] SRC_PASS, // Passed requests
  input wire logic IRQ_REQ, // Presented request
  input wire logic [3:0] IRQ_SRC, // Winner index
  input wire logic [2:0] IRQ_LEVEL, // Winner level
  input wire logic BLOCK_ACTIVE // Window open
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks live in the one system clock domain
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  chk_pass_flag: assert property (
    (SRC_PASS & ~$past(SRC_FLAG)) == 15'h0000) else $error("pass w/o flag");
  chk_req_any: assert property (
    IRQ_REQ == (SRC_PASS != 15'h0000)) else $error("request mismatch");
  chk_src_win: assert property (
    IRQ_REQ |-> SRC_PASS[IRQ_SRC]) else $error("winner not passed");
  chk_level_on: assert property (
    IRQ_REQ |-> IRQ_LEVEL != 3'h0) else $error("level zero presented");
  chk_block_top: assert property (
    $past(BLOCK_ACTIVE) && IRQ_REQ |-> IRQ_LEVEL == 3'h7)
    else $error("low level in window");
  chk_start_open: assert property (
    BLOCK_START && BLOCK_COUNT != '0 |=> BLOCK_ACTIVE)
    else $error("window not opened");
  chk_fall_done: assert property (
    $fell(BLOCK_ACTIVE) && $past(RST_N) |-> $past(INSN_DONE)
    || $past(BLOCK_START)) else $error("window closed early");
  chk_rst_quiet: assert property (
    $rose(RST_N) |-> (SRC_PASS == 15'h0000)[*3])
    else $error("pass after reset");
  // Main scenarios reached
  cover property (BLOCK_ACTIVE && IRQ_REQ);
  cover property (PREADY && PSLVERR);
  cover property ($fell(BLOCK_ACTIVE));
endmodule
bind iep_bank iep_bank_sva #(.BLOCK_W(BLOCK_W)) u_sva (.SYS_CLK(SYS_CLK),
  .RST_N(RST_N), .PREADY(PREADY), .PSLVERR(PSLVERR), .SRC_FLAG(SRC_FLAG),
  .BLOCK_START(BLOCK_START), .BLOCK_COUNT(BLOCK_COUNT),
  .INSN_DONE(INSN_DONE), .SRC_PASS(SRC_PASS), .IRQ_REQ(IRQ_REQ),
  .IRQ_SRC(IRQ_SRC), .IRQ_LEVEL(IRQ_LEVEL), .BLOCK_ACTIVE(BLOCK_ACTIVE));
`default_nettype wire

// ---- sim/iep_core_model.sv ----
// Behavioural core that retires instructions promptly or slowly
`default_nettype none
module iep_core_model (
  input wire logic clk, // System clock
  input wire logic run, // Core executing
  input wire logic slow, // One retire per two cycles
  output logic insn_done // Retire pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_q = 1'h0;
  initial insn_done = 1'h0;
  // Pulses change just after the edge, never on the falling one
  always @(posedge clk) begin
    ph_q <= ~ph_q;
    insn_done <= run && (!slow || ph_q);
  end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench of the enable/priority bank
`include "iep_consts.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, bstart = 1'h0, run = 1'h0, slow = 1'h0;
  logic pready, pslverr, e, ireq, bact, notify, idone;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [13:0] bcount = '0;
  logic [14:0] flag = '0, pass;
  logic [3:0] isrc;
  logic [2:0] ilvl;
  logic [15:0] en, p;
  logic [21:0] x;
  int error_cnt = 0, checks = 0;
  always #10 clk = ~clk;
  iep_bank #(.BLOCK_W(14)) u_dut (.SYS_CLK(clk), .RST_N(rst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SRC_FLAG(flag), .BLOCK_START(bstart),
    .BLOCK_COUNT(bcount), .INSN_DONE(idone), .SRC_PASS(pass),
    .IRQ_REQ(ireq), .IRQ_SRC(isrc), .IRQ_LEVEL(ilvl),
    .BLOCK_ACTIVE(bact), .IRQ_NOTIFY(notify));
  iep_core_model u_core (.clk(clk), .run(run), .slow(slow),
    .insn_done(idone));
  // Level of each source; sources without a field use the fixed level
  function automatic logic [2:0] lv(input int i);
    case (i)
      11: return p[14:12];
      10: return p[10:8];
      9: return p[6:4];
      8: return p[2:0];
      default: return `IEP_OTHER_LEVEL;
    endcase
  endfunction
  // Expected passed set, winner level and index; ties go to lower index
  function automatic logic [21:0] exp_out(input logic b);
    logic [14:0] ps;
    logic [2:0] bl;
    logic [3:0] bs;
    ps = '0;
    bl = 3'h0;
    bs = 4'h0;
    for (int i = 0; i < 15; i++) begin
      if (flag[i] && en[i] && lv(i) != 3'h0 && (!b || lv(i) == 3'h7)) begin
        ps[i] = 1'h1;
        if (lv(i) > bl) begin
          bl = lv(i);
          bs = 4'(i);
        end
      end
    end
    return {ps, bl, bs};
  endfunction
  task automatic give_verdict();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] x);
    checks++;
    if (got !== x) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, x);
    end
  endtask
  // Request held until pready is seen high at a falling edge, then released at the next rising edge
  // Ready is looked at mid-cycle, where it has settled, so no edge race
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(negedge clk);
    for (int n = 0; n < 9 && pready !== 1'h1; n++) @(negedge clk);
    if (pready !== 1'h1) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, pready, 1'h1);
    end
    r = prdata;
    e = pslverr;
    @(posedge clk);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'h0, a, '0);
    chk(r, x);
  endtask
  // Hang guard, well beyond the roughly one thousand cycles of the tests
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  // Main sequence
  initial begin
    void'($urandom(46969));
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(`IEP_OFS_ENABLE, 32'h0000_0000);
    rd(`IEP_OFS_PRIORITY, 32'h0000_4444);
    apb(1'h0, 12'h020, '0);
    chk(32'(e), 32'h0000_0001);
    chk(r, 32'h0000_0000);
    $display("test reset done");
    // Random enables, levels and flags; all-priority-fields-off and all-enabled corners first
    for (int k = 0; k < 40; k++) begin
      en = (k == 1) ? 16'hFFFF : 16'($urandom);
      p = (k == 0) ? 16'h0000 : 16'($urandom);
      apb(1'h1, `IEP_OFS_ENABLE, {16'h0000, en});
      apb(1'h1, `IEP_OFS_PRIORITY, {16'h0000, p});
      rd(`IEP_OFS_ENABLE, {17'h0, en[14:0]});
      rd(`IEP_OFS_PRIORITY, {16'h0000, p & 16'h7777});
      flag <= 15'($urandom);
      repeat (2) @(posedge clk);
      x = exp_out(1'h0);
      chk(32'({pass, ilvl, isrc}), 32'(x));
      rd(`IEP_OFS_PASS, 32'(x[21:7]));
      rd(`IEP_OFS_PRESENT, {24'h0, 1'(x[6:4] != 3'h0), x[6:0]});
    end
    $display("test random gating done");
    // Timed block: only level seven passes while the window is open
    en = 16'h7FFF;
    p = 16'h7444;
    apb(1'h1, `IEP_OFS_ENABLE, 32'h0000_7FFF);
    apb(1'h1, `IEP_OFS_PRIORITY, 32'h0000_7444);
    apb(1'h1, `IEP_OFS_EVT_MASK, 32'h0000_0003);
    flag <= 15'h7FFF;
    bstart <= 1'h1;
    bcount <= 14'h0003;
    @(posedge clk);
    bstart <= 1'h0;
    repeat (2) @(posedge clk);
    chk(32'(bact), 32'h0000_0001);
    chk(32'({pass, ilvl, isrc}), 32'(exp_out(1'h1)));
    rd(`IEP_OFS_BLOCK, 32'h8000_0003);
    run <= 1'h1;
    slow <= 1'h1;
    for (int n = 0; n < 40 && bact !== 1'h0; n++) @(posedge clk);
    run <= 1'h0;
    repeat (3) @(posedge clk);
    chk(32'({pass, ilvl, isrc}), 32'(exp_out(1'h0)));
    $display("test timed block done");
    // Events: sticky, masked, cleared by writing ones
    rd(`IEP_OFS_EVT_STAT, 32'h0000_0003);
    chk(32'(notify), 32'h0000_0001);
    apb(1'h1, `IEP_OFS_EVT_MASK, '0);
    chk(32'(notify), 32'h0000_0000);
    apb(1'h1, `IEP_OFS_EVT_STAT, 32'h0000_0003);
    apb(1'h1, `IEP_OFS_EVT_MASK, 32'h0000_0003);
    chk(32'(notify), 32'h0000_0000);
    $display("test events done");
    give_verdict();
  end
endmodule
`default_nettype wire
